// ---- thermal_pkg.sv ----
// Constants shared by the thermal sensor serial slave and its helpers.
// Assumes a 25 MHz system clock; all timing counts derive from it.
package thermal_pkg;
  // System clock rate in Hz
  localparam int CLK_HZ = 25000000;
  // Default seven-bit slave address, binary 1001 101
  localparam logic [6:0] DEFAULT_ADDR = 7'h4D;
  // Command codes selecting the target register
  localparam logic [7:0] CMD_TEMP = 8'h00;
  localparam logic [7:0] CMD_CONFIG = 8'h01;
  // Configuration byte field positions
  localparam int CFG_STANDBY_BIT = 7;
  localparam int CFG_READY_BIT = 6;
  // Reset values
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  // Longest time from power-on to first ready result, in ms
  localparam int FIRST_CONV_MS = 250;
  // Cycles in that time, rounded down
  localparam int FIRST_CONV_CYCLES = (CLK_HZ / 1000) * FIRST_CONV_MS;
  // Nominal conversion period, in ms (eight samples per second)
  localparam int CONV_PERIOD_MS = 125;
  localparam int CONV_PERIOD_CYCLES = (CLK_HZ / 1000) * CONV_PERIOD_MS;
  // Counter width for the conversion timer
  localparam int CONV_CNT_W = 24;
  // Bits per serial byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
endpackage : thermal_pkg

// ---- line_sync.sv ----
// Two-flop synchroniser for one asynchronous pin level.
// Assumes the pin is quiet long enough for two flops to settle it.
`timescale 1ns/100ps
`default_nettype none
module line_sync (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_async,
  output logic o_sync
);
  // First stage is read only by the second stage
  logic meta_reg;

  // Idle bus level is high, so both stages reset to one
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_reg <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule // line_sync
`default_nettype wire

// ---- conv_timer.sv ----
// Conversion timer: issues a one-cycle sample strobe each period.
// Assumes standby is a synchronous level from the same clock.
`timescale 1ns/100ps
`default_nettype none
module conv_timer #(
  parameter int FIRST_CYCLES = thermal_pkg::FIRST_CONV_CYCLES,
  parameter int PERIOD_CYCLES = thermal_pkg::CONV_PERIOD_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_standby,
  output logic o_sample
);
  // Cycles left until the next conversion completes
  logic [thermal_pkg::CONV_CNT_W-1:0] count_reg;
  wire count_zero = (count_reg == '0);

  // Counter halts in standby so no new sample is produced
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count_reg <= thermal_pkg::CONV_CNT_W'(FIRST_CYCLES - 1);
      o_sample <= 1'b0;
    end else if (i_standby) begin
      o_sample <= 1'b0;
    end else if (count_zero) begin
      count_reg <= thermal_pkg::CONV_CNT_W'(PERIOD_CYCLES - 1);
      o_sample <= 1'b1;
    end else begin
      count_reg <= count_reg - 1'b1;
      o_sample <= 1'b0;
    end
  end
endmodule // conv_timer
`default_nettype wire

// ---- temp_sensor_serial_slave.sv ----
// Thermal sensor core with a two-wire serial slave port.
// Assumes the host master drives the serial clock and pull-ups on both lines.
`timescale 1ns/100ps
`default_nettype none
module temp_sensor_serial_slave #(
  parameter logic [6:0] SLAVE_ADDR = thermal_pkg::DEFAULT_ADDR,
  parameter int FIRST_CYCLES = thermal_pkg::FIRST_CONV_CYCLES,
  parameter int PERIOD_CYCLES = thermal_pkg::CONV_PERIOD_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [7:0] i_sensor_temp,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_standby,
  output logic o_data_ready,
  output logic [7:0] o_temp
);
  // Serial engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_RXBYTE, ST_TXBYTE, ST_TXACK, ST_IGNORE
  } bus_state_t;

  // Synchronised pin levels and their previous samples
  logic scl_s, sda_s, scl_d_reg, sda_d_reg;
  line_sync u_sync_scl (.i_clk(i_clk), .i_reset(i_reset), .i_async(i_scl), .o_sync(scl_s));
  line_sync u_sync_sda (.i_clk(i_clk), .i_reset(i_reset), .i_async(i_sda), .o_sync(sda_s));

  // Conversion strobe from the timer
  logic sample;
  conv_timer #(
    .FIRST_CYCLES(FIRST_CYCLES),
    .PERIOD_CYCLES(PERIOD_CYCLES)
  ) u_timer (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_standby(o_standby),
    .o_sample(sample)
  );

  // Bus event decode from synchronised levels
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Protocol state
  bus_state_t state_reg, state_next;
  logic [7:0] shift_reg; // Received or transmitted byte
  logic [3:0] bit_cnt_reg; // Clock pulses seen in the current nine-pulse slot
  logic rw_reg; // Direction of the current transfer
  logic cmd_seen_reg; // Command byte already taken this transfer
  logic [7:0] cmd_reg; // Last command byte, kept across transfers
  logic ack_master_reg; // Host acknowledged the last read byte
  logic sda_oe_next; // Next level of the data-line pull-down

  // Pulse number of the acknowledge clock, one past the last data bit
  wire [3:0] ack_slot = thermal_pkg::BYTE_BITS + 4'h1;
  // Idle and ignore only watch for start and stop; other states count pulses
  wire active = (state_reg != ST_IDLE) && (state_reg != ST_IGNORE);
  // Either acknowledge slot: ours after a received byte, the host's after a sent one
  wire in_ack = (state_reg == ST_ACK) || (state_reg == ST_TXACK);
  // States that shift the data line in on each rising clock
  wire rx_state = (state_reg == ST_ADDR) || (state_reg == ST_RXBYTE);
  // Byte just completed, including the bit sampled at this rising edge
  wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
  wire byte_done = scl_rise && active && !in_ack
                   && (bit_cnt_reg == thermal_pkg::BYTE_BITS - 4'h1);
  // Fall after the eighth bit opens the acknowledge slot
  wire ack_open = scl_fall && in_ack && (bit_cnt_reg == thermal_pkg::BYTE_BITS);
  // Fall after the ninth pulse closes it and starts the next byte
  wire ack_close = scl_fall && in_ack && (bit_cnt_reg == ack_slot);
  // Falls inside a sent byte move the next bit onto the line
  wire tx_shift = scl_fall && (state_reg == ST_TXBYTE) && (bit_cnt_reg != 4'h0)
                  && (bit_cnt_reg < thermal_pkg::BYTE_BITS);
  // Another byte goes out after a read address, or after a host acknowledge
  wire tx_next = ack_close && ((state_reg == ST_ACK) ? rw_reg : ack_master_reg);
  wire addr_match = (rx_byte[7:1] == SLAVE_ADDR);
  wire sel_config = (cmd_reg == thermal_pkg::CMD_CONFIG);
  // Config byte read view: standby switch and ready flag, rest zero
  wire [7:0] config_view = {o_standby, o_data_ready, 6'h00};
  // Stored register is returned, never the live converter input
  wire [7:0] read_data = sel_config ? config_view : o_temp;
  wire rx_data_byte = byte_done && (state_reg == ST_RXBYTE) && cmd_seen_reg;
  wire cfg_write = rx_data_byte && sel_config;

  // Next-state decode of the serial engine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: state_next = ST_IDLE;
      ST_ADDR: begin
        if (byte_done) begin
          state_next = addr_match ? ST_ACK : ST_IGNORE;
        end
      end
      ST_ACK: begin
        // Leave only after the whole ninth pulse, not at the eighth fall
        if (ack_close) begin
          state_next = rw_reg ? ST_TXBYTE : ST_RXBYTE;
        end
      end
      ST_RXBYTE: begin
        if (byte_done) begin
          state_next = ST_ACK;
        end
      end
      ST_TXBYTE: begin
        if (byte_done) begin
          state_next = ST_TXACK;
        end
      end
      ST_TXACK: begin
        // A missing host acknowledge ends the read; wait for stop
        if (ack_close) begin
          state_next = ack_master_reg ? ST_TXBYTE : ST_IGNORE;
        end
      end
      ST_IGNORE: state_next = ST_IGNORE;
    endcase
    // Start and stop override any state
    if (start_cond) begin
      state_next = ST_ADDR;
    end else if (stop_cond) begin
      state_next = ST_IDLE;
    end
  end

  // Pin history for edge detection
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // State register; port runs regardless of standby
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bit counter and shifter: sample on rising, shift out on falling
  // The counter runs one to nine so the acknowledge pulse has its own slot
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end else if (start_cond) begin
      bit_cnt_reg <= 4'h0;
    end else if (ack_close) begin
      // Loaded every time; only a sent byte uses it, a received one shifts over it
      bit_cnt_reg <= 4'h0;
      shift_reg <= read_data;
    end else if (tx_shift) begin
      shift_reg <= {shift_reg[6:0], 1'b0};
    end else if (scl_rise && active && (bit_cnt_reg != ack_slot)) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (rx_state) begin
        shift_reg <= rx_byte;
      end
    end
  end

  // Transfer bookkeeping: direction, command capture, host acknowledge
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rw_reg <= 1'b0;
      cmd_seen_reg <= 1'b0;
      cmd_reg <= thermal_pkg::CMD_RESET;
      ack_master_reg <= 1'b0;
    end else begin
      if (start_cond) begin
        cmd_seen_reg <= 1'b0;
      end
      if (byte_done && state_reg == ST_ADDR) begin
        rw_reg <= rx_byte[0];
      end
      if (byte_done && state_reg == ST_RXBYTE && !cmd_seen_reg) begin
        cmd_reg <= rx_byte;
        cmd_seen_reg <= 1'b1;
      end
      // Host answer is sampled on the ninth rising clock only
      if (scl_rise && state_reg == ST_TXACK && bit_cnt_reg == thermal_pkg::BYTE_BITS) begin
        ack_master_reg <= ~sda_s;
      end
    end
  end

  // Data line drive: low for acknowledge or a zero data bit, else released
  // Changes follow a clock fall, apart from the release on start or stop, so the device never makes a false start or stop
  always_comb begin
    sda_oe_next = o_sda_oe;
    if (start_cond || stop_cond) begin
      sda_oe_next = 1'b0;
    end else if (ack_open) begin
      // Our slot pulls low; the host's slot is left released for its answer
      sda_oe_next = (state_reg == ST_ACK);
    end else if (ack_close) begin
      // Ack released; first bit of a read byte goes out at once
      sda_oe_next = tx_next && !read_data[7];
    end else if (tx_shift) begin
      sda_oe_next = !shift_reg[6];
    end
  end

  // Open-drain output: the level driven is always low
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      o_sda_oe <= sda_oe_next;
      o_sda_out <= 1'b0;
    end
  end

  // Configuration: host writes the standby switch via the serial port
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_standby <= 1'b0;
    end else if (cfg_write) begin
      o_standby <= rx_byte[thermal_pkg::CFG_STANDBY_BIT];
    end
  end

  // Temperature store: whole byte updates only on a conversion strobe
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_temp <= thermal_pkg::TEMP_RESET;
      o_data_ready <= 1'b0;
    end else if (sample && !o_standby) begin
      o_temp <= i_sensor_temp;
      o_data_ready <= 1'b1;
    end
  end

  // Checks on the stored temperature and port behaviour
  sequence seq_addr_other;
    (state_reg == ST_ADDR) && byte_done && !addr_match;
  endsequence

  // The acknowledge pulse of a received byte
  sequence seq_ack_slot;
    (state_reg == ST_ACK) && (bit_cnt_reg == ack_slot);
  endsequence

  AST_ACK_HELD: assert property (@(posedge i_clk) disable iff (i_reset)
    seq_ack_slot |-> o_sda_oe) else $error("acknowledge not driven");

  AST_READY_BY_LIMIT: assert property (@(posedge i_clk) disable iff (i_reset)
    sample |=> o_data_ready) else $error("ready flag not set after conversion");
  AST_STANDBY_FREEZE: assert property (@(posedge i_clk) disable iff (i_reset)
    o_standby && $stable(o_standby) |=> $stable(o_temp)) else $error("temp changed in standby");
  AST_PORT_IN_STANDBY: assert property (@(posedge i_clk) disable iff (i_reset)
    start_cond |=> state_reg == ST_ADDR) else $error("port ignored start");
  AST_STANDBY_WRITE: assert property (@(posedge i_clk) disable iff (i_reset)
    cfg_write |=> o_standby == $past(rx_byte[thermal_pkg::CFG_STANDBY_BIT]))
    else $error("standby bit not written");
  AST_NACK_OTHER: assert property (@(posedge i_clk) disable iff (i_reset)
    seq_addr_other |=> state_reg == ST_IGNORE) else $error("foreign address accepted");
  AST_SILENT_IGNORE: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_reg == ST_IGNORE) && $past(state_reg == ST_IGNORE) |-> !o_sda_oe)
    else $error("drove line while ignoring");
  AST_TEMP_FROM_SAMPLE: assert property (@(posedge i_clk) disable iff (i_reset)
    !$past(sample) |-> $stable(o_temp)) else $error("temp changed without sample");
  AST_ACK_WRITE: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_reg == ST_RXBYTE) && byte_done && !start_cond && !stop_cond |=> state_reg == ST_ACK)
    else $error("written byte not acknowledged");
endmodule // temp_sensor_serial_slave
`default_nettype wire

// ---- host_model.sv ----
// Host master model for the two-wire port: makes the serial clock and frames.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/100ps
`default_nettype none
module host_model #(
  parameter int Q = 63 // Quarter bit in clocks, keeps the bus just under 100 kHz
) (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  // Idle bus: both lines high, clock stands still between frames
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic wt();
    repeat (Q) @(negedge i_clk);
  endtask
  // One bit; data moves only while the clock is low
  task automatic bitx(input logic v, output logic s);
    o_sda_oe = ~v;
    wt();
    o_scl = 1'b1;
    wt();
    s = i_sda;
    wt();
    o_scl = 1'b0;
    wt();
  endtask
  // Start, also used as repeated start
  task automatic start();
    o_sda_oe = 1'b0;
    wt();
    o_scl = 1'b1;
    wt();
    o_sda_oe = 1'b1;
    wt();
    o_scl = 1'b0;
    wt();
  endtask
  task automatic stop();
    o_sda_oe = 1'b1;
    wt();
    o_scl = 1'b1;
    wt();
    o_sda_oe = 1'b0;
    wt();
  endtask
  // Byte out, MSB first; ack is the slave pulling the ninth bit low
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask
  // Byte in; last leaves the ninth bit high (no ack)
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
    bitx(last, s);
  endtask
endmodule // host_model
`default_nettype wire

// ---- temp_sensor_serial_slave_tb_top.sv ----
// Self-checking bench for the thermal sensor serial slave.
// Assumes host_model on the far side and shortened conversion counts.
`timescale 1ns/100ps
`default_nettype none
module temp_sensor_serial_slave_tb_top;
  localparam int FIRST = 50; // Stands for the 250 ms first result
  localparam int PERIOD = 40;
  localparam logic [7:0] AW = {thermal_pkg::DEFAULT_ADDR, 1'b0};
  localparam logic [7:0] AR = {thermal_pkg::DEFAULT_ADDR, 1'b1};
  localparam logic [7:0] CT = thermal_pkg::CMD_TEMP;
  localparam logic [7:0] CC = thermal_pkg::CMD_CONFIG;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sens = 8'h19; // Live converter value
  logic scl, h_oe, d_out, d_oe, stby, rdy, sda;
  logic [7:0] temp;
  logic [7:0] v;
  int num_errors = 0;
  int n_tests = 0;
  // Open-drain data wire with pull-up
  assign sda = (d_oe ? d_out : 1'b1) & ~h_oe;
  always #20 clk = ~clk;
  temp_sensor_serial_slave #(.FIRST_CYCLES(FIRST), .PERIOD_CYCLES(PERIOD)) dut (
    .i_clk(clk), .i_reset(reset), .i_scl(scl), .i_sda(sda), .i_sensor_temp(sens),
    .o_sda_out(d_out), .o_sda_oe(d_oe), .o_standby(stby), .o_data_ready(rdy),
    .o_temp(temp));
  host_model host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ack(input string n, input logic e, input logic g);
    chk(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Write byte transfer; e is whether the slave should answer
  task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
                    input logic e);
    logic k;
    host.start();
    host.wbyte(a, k);
    ack("addr_ack", e, k);
    host.wbyte(c, k);
    ack("cmd_ack", e, k);
    host.wbyte(d, k);
    ack("data_ack", e, k);
    host.stop();
  endtask
  // Read byte (with command) or receive byte (without)
  task automatic rd(input logic cf, input logic [7:0] c, output logic [7:0] r);
    logic k;
    host.start();
    if (cf) begin
      host.wbyte(AW, k);
      ack("wr_ack", 1'b1, k);
      host.wbyte(c, k);
      ack("cmd_ack", 1'b1, k);
      host.start();
    end
    host.wbyte(AR, k);
    ack("rd_ack", 1'b1, k);
    host.rbyte(1'b1, r);
    host.stop();
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Outputs idle in reset, then first result within the bound
  task automatic t_first();
    int n;
    chk("temp_rst", thermal_pkg::TEMP_RESET, temp);
    ack("rdy_rst", 1'b0, rdy);
    ack("stby_rst", 1'b0, stby);
    reset = 1'b0;
    n = 0;
    while (rdy !== 1'b1 && n < FIRST + 10) begin
      cyc(1);
      n++;
    end
    if (rdy !== 1'b1) begin
      num_errors++;
      $display("[ERR] ready expected 1 seen %b", rdy);
      stop_test();
    end else begin
      chk("first_temp", 8'h19, temp);
      $display("t_first done");
    end
  endtask
  // Negative reading stored and read back
  task automatic t_read();
    sens = 8'hE7;
    cyc(PERIOD + 5);
    chk("temp_neg", 8'hE7, temp);
    rd(1'b1, CT, v);
    chk("rd_temp", 8'hE7, v);
    $display("t_read done");
  endtask
  // Standby freezes the result while the port keeps answering
  task automatic t_standby();
    wr(AW, CC, 8'h80, 1'b1);
    cyc(5);
    ack("stby_on", 1'b1, stby);
    rd(1'b0, CT, v);
    chk("rd_cfg", 8'hC0, v);
    sens = 8'h3C;
    cyc(3 * PERIOD);
    chk("frozen", 8'hE7, temp);
    rd(1'b1, CT, v);
    chk("rd_stby", 8'hE7, v);
    wr(AW, CC, 8'h00, 1'b1);
    cyc(PERIOD + 5);
    ack("stby_off", 1'b0, stby);
    chk("resumed", 8'h3C, temp);
    $display("t_standby done");
  endtask
  // Temperature write ignored; foreign address left unanswered
  task automatic t_ignore();
    wr(AW, CT, 8'h55, 1'b1);
    chk("temp_ro", 8'h3C, temp);
    rd(1'b0, CT, v);
    chk("rd_last", 8'h3C, v);
    wr({thermal_pkg::DEFAULT_ADDR ^ 7'h01, 1'b0}, CC, 8'h80, 1'b0);
    ack("foreign", 1'b0, stby);
    $display("t_ignore done");
  endtask
  // Main sequence
  initial begin
    cyc(20);
    t_first();
    t_read();
    t_standby();
    t_ignore();
    stop_test();
  end
endmodule // temp_sensor_serial_slave_tb_top
`default_nettype wire
